// [logic/card_timing_pkg.sv]
package card_timing_pkg;

   localparam int ADDR_W = 18;
   localparam int DATA_W = 32;

   // register indices; byte address is four times the index
   localparam logic [15:0] IDX_SUPPLY_CTL    = 16'hFE03;
   localparam logic [15:0] IDX_SIGNAL_CTL    = 16'hFE0A;
   localparam logic [15:0] IDX_PROTOCOL_CFG  = 16'hFE0D;
   localparam logic [15:0] IDX_BYTE_TIMING   = 16'hFE12;
   localparam logic [15:0] IDX_FD_CTL        = 16'hFE13;
   localparam logic [15:0] IDX_ATR_HIGH      = 16'hFE1F;
   localparam logic [15:0] IDX_ATR_LOW       = 16'hFE20;
   localparam logic [15:0] IDX_INIT_CHAR     = 16'hFE21;
   localparam logic [15:0] IDX_RELEASE_DELAY = 16'hFE22;
   localparam logic [15:0] IDX_TIMER_STATUS  = 16'hFE24;

   localparam logic [7:0] RST_SUPPLY_CTL    = 8'h00;
   localparam logic [7:0] RST_SIGNAL_CTL    = 8'h00;
   localparam logic [7:0] RST_PROTOCOL_CFG  = 8'h00;
   localparam logic [7:0] RST_BYTE_TIMING   = 8'h00;
   localparam logic [7:0] RST_FD_CTL        = 8'h11;
   localparam logic [7:0] RST_ATR_HIGH      = 8'h00;
   localparam logic [7:0] RST_ATR_LOW       = 8'h00;
   localparam logic [7:0] RST_INIT_CHAR     = 8'h00;
   localparam logic [7:0] RST_RELEASE_DELAY = 8'h70;

   localparam int BIT_SUPPLY_GOOD    = 3;
   localparam int BIT_RESET_HOLD     = 7;
   localparam int BIT_ANSWER_RX_EN   = 0;
   localparam int BIT_INIT_DETECT_EN = 6;
   localparam int BIT_STAT_ANSWER_TO = 0;
   localparam int BIT_STAT_MUTE      = 1;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // etu = intermediate clock period * ETU_CLK_MULT * Fi/Di
   localparam logic [3:0] ETU_CLK_MULT = 4'h2;

   typedef enum logic [3:0] {
      REG_NONE, REG_SUPPLY, REG_SIGNAL, REG_PROTOCOL, REG_BYTE_TIMING, REG_FD,
      REG_ATR_HIGH, REG_ATR_LOW, REG_INIT_CHAR, REG_RELEASE_DELAY, REG_STATUS
   } reg_id_t;

   // gray order along hold -> delay -> released
   typedef enum logic [1:0] {
      ST_HOLD     = 2'b00,
      ST_DELAY    = 2'b01,
      ST_RELEASED = 2'b11
   } rst_state_t;

   function automatic reg_id_t decode_reg(input logic [ADDR_W-1:0] addr);
      reg_id_t id;
      id = REG_NONE;
      if (addr[1:0] == 2'h0)
      begin
         case (addr[17:2])
            IDX_SUPPLY_CTL:    id = REG_SUPPLY;
            IDX_SIGNAL_CTL:    id = REG_SIGNAL;
            IDX_PROTOCOL_CFG:  id = REG_PROTOCOL;
            IDX_BYTE_TIMING:   id = REG_BYTE_TIMING;
            IDX_FD_CTL:        id = REG_FD;
            IDX_ATR_HIGH:      id = REG_ATR_HIGH;
            IDX_ATR_LOW:       id = REG_ATR_LOW;
            IDX_INIT_CHAR:     id = REG_INIT_CHAR;
            IDX_RELEASE_DELAY: id = REG_RELEASE_DELAY;
            IDX_TIMER_STATUS:  id = REG_STATUS;
            default:           id = REG_NONE;
         endcase
      end
      return id;
   endfunction

endpackage

// [logic/etu_tick_gen.sv]
`timescale 1ns/1ps
module etu_tick_gen
   import card_timing_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic       card_clk_tick,
   input  wire logic [3:0] fi_code,
   input  wire logic [3:0] di_code,
   output logic            etu_tick
);

   logic [11:0] fi_ratio;
   logic [5:0]  di_ratio;
   logic [12:0] period;
   logic [12:0] acc_reg;
   logic [13:0] sum;

   always_comb
   begin
      case (fi_code)
         4'h0, 4'h1: fi_ratio = 12'h174;
         4'h2:       fi_ratio = 12'h22E;
         4'h3:       fi_ratio = 12'h2E8;
         4'h4:       fi_ratio = 12'h45C;
         4'h5:       fi_ratio = 12'h5D0;
         4'h6, 4'h7: fi_ratio = 12'h744;
         4'h8, 4'h9: fi_ratio = 12'h200;
         4'hA:       fi_ratio = 12'h300;
         4'hB:       fi_ratio = 12'h400;
         4'hC:       fi_ratio = 12'h600;
         default:    fi_ratio = 12'h800;
      endcase
      case (di_code)
         4'h0, 4'h1: di_ratio = 6'h01;
         4'h2:       di_ratio = 6'h02;
         4'h3:       di_ratio = 6'h04;
         4'h4:       di_ratio = 6'h08;
         4'h5:       di_ratio = 6'h10;
         4'h6, 4'h7: di_ratio = 6'h20;
         4'h8:       di_ratio = 6'h0C;
         4'h9:       di_ratio = 6'h14;
         default:    di_ratio = 6'h10;
      endcase
   end

   // accumulate Di per intermediate clock, wrap at 2*Fi: exact for 12 and 20 too
   assign period = 13'(fi_ratio) * 13'(ETU_CLK_MULT);
   assign sum    = {1'b0, acc_reg} + 14'(di_ratio);

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         acc_reg  <= 13'h0000;
         etu_tick <= 1'b0;
      end
      else
      begin
         etu_tick <= 1'b0;
         if (card_clk_tick)
         begin
            if (sum >= {1'b0, period})
            begin
               acc_reg  <= 13'(sum - {1'b0, period});
               etu_tick <= 1'b1;
            end
            else
            begin
               acc_reg <= sum[12:0];
            end
         end
      end
   end

endmodule

// [logic/etu_limit_timer.sv]
`timescale 1ns/1ps
module etu_limit_timer
   import card_timing_pkg::*;
#(
   parameter int W = 16
)
(
   input  wire logic         ref_clk,
   input  wire logic         rst,
   input  wire logic         clear,
   input  wire logic         run,
   input  wire logic         etu_tick,
   input  wire logic [W-1:0] limit,
   output logic              expired
);

   logic [W-1:0] count_reg;
   logic         done_reg;

   // one expiry per clear; counter stops so it cannot wrap and refire
   always_ff @(posedge ref_clk)
   begin
      if (rst || clear)
      begin
         count_reg <= '0;
         done_reg  <= 1'b0;
         expired   <= 1'b0;
      end
      else
      begin
         expired <= 1'b0;
         if (run && etu_tick && !done_reg)
         begin
            if (count_reg == limit)
            begin
               done_reg <= 1'b1;
               expired  <= 1'b1;
            end
            else
            begin
               count_reg <= count_reg + 1'b1;
            end
         end
      end
   end

endmodule

// [logic/card_reset_atr_timer.sv]
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module card_reset_atr_timer
   import card_timing_pkg::*;
#(
   parameter int NUM_IF = 2,
   parameter int SEL_W  = 1
)
(
   input  wire logic              ref_clk,
   input  wire logic              rst,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [DATA_W-1:0]      s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic              intermediate_card_clock,
   input  wire logic              card_supply_good,
   input  wire logic              rx_start_bit,
   input  wire logic [SEL_W-1:0]  interface_select,
   output logic [NUM_IF-1:0]      card_rst_n,
   output logic                   answer_timeout,
   output logic                   mute_card
);

   ////////////////////////////////////////////////////////////////////////////
   logic [7:0]        supply_ctl_reg;
   logic [7:0]        signal_ctl_reg;
   logic [7:0]        protocol_cfg_reg;
   logic [7:0]        byte_timing_reg;
   logic [7:0]        fd_ctl_reg;
   logic [7:0]        atr_high_reg;
   logic [7:0]        atr_low_reg;
   logic [7:0]        init_char_reg;
   logic [7:0]        release_delay_reg;
   logic              aw_held_reg;
   logic              w_held_reg;
   logic [ADDR_W-1:0] waddr_reg;
   logic [7:0]        wdata_reg;
   logic              wlane_reg;
   logic              do_write;
   reg_id_t           wr_id;
   reg_id_t           rd_id;
   logic [7:0]        rd_byte;
   logic              wr_status;
   logic              etu_tick;
   rst_state_t        state_reg;
   rst_state_t        state_next;
   logic [7:0]        delay_cnt_reg;
   logic              hold_req;
   logic              release_evt;
   logic              ts_run_reg;
   logic              atr_run_reg;
   logic              ts_expired;
   logic              atr_expired;
   logic [15:0]       answer_timeout_limit;
   logic              answer_receive_enable;
   logic              initial_char_detect_enable;
   logic              card_reset_hold;

   assign answer_receive_enable      = protocol_cfg_reg[BIT_ANSWER_RX_EN];
   assign initial_char_detect_enable = byte_timing_reg[BIT_INIT_DETECT_EN];
   assign card_reset_hold            = signal_ctl_reg[BIT_RESET_HOLD];
   assign answer_timeout_limit       = {atr_high_reg, atr_low_reg};

   ////////////////////////////////////////////////////////////////////////////
   // write channel: address and data taken in either order
   assign s_axi_awready = !aw_held_reg;
   assign s_axi_wready  = !w_held_reg;
   assign do_write      = aw_held_reg && w_held_reg && !s_axi_bvalid;
   assign wr_id         = decode_reg(waddr_reg);
   assign wr_status     = do_write && wlane_reg && (wr_id == REG_STATUS);

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         aw_held_reg  <= 1'b0;
         w_held_reg   <= 1'b0;
         waddr_reg    <= '0;
         wdata_reg    <= 8'h00;
         wlane_reg    <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_reg <= 1'b1;
            waddr_reg   <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata[7:0];
            wlane_reg  <= s_axi_wstrb[0];
         end
         if (do_write)
         begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_id == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // only byte lane 0 carries register bits
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         supply_ctl_reg    <= RST_SUPPLY_CTL;
         signal_ctl_reg    <= RST_SIGNAL_CTL;
         protocol_cfg_reg  <= RST_PROTOCOL_CFG;
         byte_timing_reg   <= RST_BYTE_TIMING;
         fd_ctl_reg        <= RST_FD_CTL;
         atr_high_reg      <= RST_ATR_HIGH;
         atr_low_reg       <= RST_ATR_LOW;
         init_char_reg     <= RST_INIT_CHAR;
         release_delay_reg <= RST_RELEASE_DELAY;
      end
      else if (do_write && wlane_reg)
      begin
         case (wr_id)
            REG_SUPPLY:        supply_ctl_reg    <= wdata_reg;
            REG_SIGNAL:        signal_ctl_reg    <= wdata_reg;
            REG_PROTOCOL:      protocol_cfg_reg  <= wdata_reg;
            REG_BYTE_TIMING:   byte_timing_reg   <= wdata_reg;
            REG_FD:            fd_ctl_reg        <= wdata_reg;
            REG_ATR_HIGH:      atr_high_reg      <= wdata_reg;
            REG_ATR_LOW:       atr_low_reg       <= wdata_reg;
            REG_INIT_CHAR:     init_char_reg     <= wdata_reg;
            REG_RELEASE_DELAY: release_delay_reg <= wdata_reg;
            default:           ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read channel: one cycle to rvalid
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_id         = decode_reg(s_axi_araddr);

   always_comb
   begin
      case (rd_id)
         REG_SUPPLY:        rd_byte = {supply_ctl_reg[7:4], card_supply_good,
                                       supply_ctl_reg[2:0]};
         REG_SIGNAL:        rd_byte = signal_ctl_reg;
         REG_PROTOCOL:      rd_byte = protocol_cfg_reg;
         REG_BYTE_TIMING:   rd_byte = byte_timing_reg;
         REG_FD:            rd_byte = fd_ctl_reg;
         REG_ATR_HIGH:      rd_byte = atr_high_reg;
         REG_ATR_LOW:       rd_byte = atr_low_reg;
         REG_INIT_CHAR:     rd_byte = init_char_reg;
         REG_RELEASE_DELAY: rd_byte = release_delay_reg;
         REG_STATUS:        rd_byte = {6'h00, mute_card, answer_timeout};
         default:           rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= {24'h00_0000, rd_byte};
         s_axi_rresp  <= (rd_id == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   etu_tick_gen u_etu
   (
      .ref_clk    (ref_clk),
      .rst        (rst),
      .card_clk_tick (intermediate_card_clock),
      .fi_code    (fd_ctl_reg[7:4]),
      .di_code    (fd_ctl_reg[3:0]),
      .etu_tick   (etu_tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // card reset sequencing; no supply means the selected interface's reset is held regardless
   assign hold_req = card_reset_hold || !card_supply_good;

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ST_HOLD:
         begin
            if (!hold_req)
               state_next = (release_delay_reg == 8'h00) ? ST_RELEASED : ST_DELAY;
         end
         ST_DELAY:
         begin
            if (hold_req)
               state_next = ST_HOLD;
            else if (etu_tick && (delay_cnt_reg + 8'h01 == release_delay_reg))
               state_next = ST_RELEASED;
         end
         ST_RELEASED:
         begin
            if (hold_req)
               state_next = ST_HOLD;
         end
         default: state_next = ST_HOLD;
      endcase
   end

   assign release_evt = (state_next == ST_RELEASED) && (state_reg != ST_RELEASED);

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         state_reg     <= ST_HOLD;
         delay_cnt_reg <= 8'h00;
      end
      else
      begin
         state_reg <= state_next;
         if (state_reg != ST_DELAY)
            delay_cnt_reg <= 8'h00;
         else if (etu_tick)
            delay_cnt_reg <= delay_cnt_reg + 8'h01;
      end
   end

   // unselected interfaces keep their last level
   genvar gi;
   generate
      for (gi = 0; gi < NUM_IF; gi++)
      begin : g_if
         always_ff @(posedge ref_clk)
         begin
            if (rst)
               card_rst_n[gi] <= 1'b0;
            else if (interface_select == SEL_W'(gi))
               card_rst_n[gi] <= (state_next == ST_RELEASED);
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // initial character timer: release until first start bit
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         ts_run_reg <= 1'b0;
      else if (!initial_char_detect_enable || hold_req || rx_start_bit)
         ts_run_reg <= 1'b0;
      else if (release_evt)
         ts_run_reg <= 1'b1;
   end

   etu_limit_timer #(.W(8)) u_ts_timer
   (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .clear    (release_evt),
      .run      (ts_run_reg),
      .etu_tick (etu_tick),
      .limit    (init_char_reg),
      .expired  (ts_expired)
   );

   // answer timer: firmware clears the enable after the last character
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         atr_run_reg <= 1'b0;
      else if (!answer_receive_enable)
         atr_run_reg <= 1'b0;
      else if (rx_start_bit)
         atr_run_reg <= 1'b1;
   end

   etu_limit_timer #(.W(16)) u_atr_timer
   (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .clear    (!answer_receive_enable),
      .run      (atr_run_reg),
      .etu_tick (etu_tick),
      .limit    (answer_timeout_limit),
      .expired  (atr_expired)
   );

   ////////////////////////////////////////////////////////////////////////////
   // sticky flags, write one to clear; a new expiry beats the clear
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         answer_timeout <= 1'b0;
         mute_card      <= 1'b0;
      end
      else
      begin
         if (atr_expired || ts_expired)
            answer_timeout <= 1'b1;
         else if (wr_status && wdata_reg[BIT_STAT_ANSWER_TO])
            answer_timeout <= 1'b0;
         if (ts_expired)
            mute_card <= 1'b1;
         else if (wr_status && wdata_reg[BIT_STAT_MUTE])
            mute_card <= 1'b0;
      end
   end

endmodule

// [sim/card_reset_atr_timer_asserts.sv]
`timescale 1ns/1ps
module card_reset_atr_timer_chk
   import card_timing_pkg::*;
#(
   parameter int NUM_IF = 2,
   parameter int SEL_W  = 1
)
(
   input wire logic              ref_clk,
   input wire logic              rst,
   input wire logic              s_axi_awvalid,
   input wire logic              s_axi_awready,
   input wire logic              s_axi_wvalid,
   input wire logic              s_axi_wready,
   input wire logic              s_axi_bvalid,
   input wire logic              s_axi_arvalid,
   input wire logic              s_axi_arready,
   input wire logic [DATA_W-1:0] s_axi_rdata,
   input wire logic [1:0]        s_axi_rresp,
   input wire logic              s_axi_rvalid,
   input wire logic              card_supply_good,
   input wire logic [SEL_W-1:0]  interface_select,
   input wire logic [NUM_IF-1:0] card_rst_n,
   input wire logic              answer_timeout,
   input wire logic              mute_card
);

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence

   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence

   ////////////////////////////////////////////////////////////////////////////////
   a_supply_low: assert property (
      !card_supply_good |=> !card_rst_n[$past(interface_select)])
      else $error("card reset not forced low without supply");
   a_release_supply: assert property (
      $rose(card_rst_n[interface_select]) && $stable(interface_select)
      |-> $past(card_supply_good))
      else $error("card reset released without supply");
   a_unsel_frozen: assert property (
      $stable(interface_select) |-> $stable(card_rst_n[~interface_select]))
      else $error("unselected card reset changed");
   a_reset_pins_low: assert property (
      $fell(rst) |-> card_rst_n == '0)
      else $error("card reset pins not low after reset");
   a_mute_timeout: assert property (
      $rose(mute_card) |-> answer_timeout)
      else $error("mute flag without answer timeout");
   a_flag_sticky: assert property (
      $fell(answer_timeout) || $fell(mute_card) |-> s_axi_bvalid || $past(s_axi_bvalid))
      else $error("timeout flag cleared without a write");
   a_write_resp: assert property (
      wr_taken |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   a_read_resp: assert property (
      rd_taken |=> s_axi_rvalid)
      else $error("read response late");
   a_rdata_upper: assert property (
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
      else $error("read data upper bits set");
   a_slverr_zero: assert property (
      s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == '0)
      else $error("error read returned data");

endmodule

bind card_reset_atr_timer card_reset_atr_timer_chk #(.NUM_IF(NUM_IF), .SEL_W(SEL_W)) u_chk (
   .ref_clk(ref_clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .card_supply_good(card_supply_good), .interface_select(interface_select),
   .card_rst_n(card_rst_n), .answer_timeout(answer_timeout), .mute_card(mute_card));

// [sim/card_model.sv]
`timescale 1ns/1ps
// answers with start bits a fixed gap apart once its reset line is released
module card_model
#(
   parameter int GAP  = 40,
   parameter int NCHR = 3
)
(
   input  wire logic ref_clk,
   input  wire logic rst_n_pin,
   input  wire logic mute,
   output logic      rx_start_bit
);

   int cnt = 0;
   int nch = 0;

   initial rx_start_bit = 1'b0;

   always @(posedge ref_clk)
   begin
      rx_start_bit <= 1'b0;
      if (!rst_n_pin)
      begin
         cnt <= 0;
         nch <= 0;
      end
      else if (!mute && nch < NCHR)
      begin
         if (cnt == GAP - 1)
         begin
            cnt          <= 0;
            nch          <= nch + 1;
            rx_start_bit <= 1'b1;
         end
         else
            cnt <= cnt + 1;
      end
   end

endmodule

// [sim/tb_card_reset_atr_timer.sv]
`timescale 1ns/1ps
module tb_card_reset_atr_timer
   import card_timing_pkg::*;
;

   logic              ref_clk = 1'b0;
   logic              rst;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata, d;
   logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic              s_axi_rvalid, s_axi_rready;
   logic [1:0]        s_axi_bresp, s_axi_rresp, r, card_rst_n;
   logic              card_supply_good, rx_start_bit, interface_select;
   logic              answer_timeout, mute_card, card_mute;
   int                miscompares = 0;
   int                n_tests = 0;
   int                cyc = 0;
   int                n;
   logic [15:0]       ridx [4] = '{IDX_ATR_HIGH, IDX_ATR_LOW, IDX_INIT_CHAR, IDX_RELEASE_DELAY};
   logic [7:0]        rval [4] = '{8'h00, 8'h00, 8'h00, 8'h70};
   always #25 ref_clk = ~ref_clk;

   card_reset_atr_timer i_card_reset_atr_timer (
      .ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .intermediate_card_clock(1'b1),
      .card_supply_good(card_supply_good), .rx_start_bit(rx_start_bit),
      .interface_select(interface_select), .card_rst_n(card_rst_n),
      .answer_timeout(answer_timeout), .mute_card(mute_card));

   card_model i_card_model (
      .ref_clk(ref_clk), .rst_n_pin(card_rst_n[interface_select]), .mute(card_mute),
      .rx_start_bit(rx_start_bit));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic rng(input string nm, input int v, input int lo, input int hi);
      chk(nm, {31'h0000_0000, v >= lo && v <= hi}, 32'h0000_0001);
   endtask

   task automatic wr(input logic [15:0] idx, input logic [7:0] dat);
      logic aw_ok;
      logic w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= {24'h00_0000, dat};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(aw_ok && w_ok))
      begin
         @(posedge ref_clk);
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
      chk("bresp", {30'h0000_0000, s_axi_bresp}, {30'h0000_0000, RESP_OKAY});
   endtask

   task automatic rd(input logic [15:0] idx, output logic [31:0] dat, output logic [1:0] rsp);
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
      dat = s_axi_rdata;
      rsp = s_axi_rresp;
   endtask

   function automatic logic pick(input int w);
      case (w)
         0:       return card_rst_n[interface_select];
         1:       return mute_card;
         default: return answer_timeout;
      endcase
   endfunction

   // bounded so a dead output ends up as a range miss, not a hang
   task automatic wait_on(input int w, output int cnt);
      cnt = 0;
      while (pick(w) !== 1'b1 && cnt < 2000)
      begin
         @(posedge ref_clk);
         cnt++;
      end
   endtask

   task automatic cycle_hold;
      wr(IDX_SIGNAL_CTL, 8'h80);
      wr(IDX_SIGNAL_CTL, 8'h00);
      wait_on(0, n);
   endtask

   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         miscompares++;
         test_done();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      rst = 1'b1;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
      {s_axi_bready, s_axi_rready} = 2'h3;
      {card_supply_good, interface_select, card_mute} = 3'h0;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      for (int i = 0; i < 4; i++)
      begin
         rd(ridx[i], d, r);
         chk("reset value", d, {24'h00_0000, rval[i]});
      end
      chk("pins after reset", {30'h0000_0000, card_rst_n}, 32'h0000_0000);
      rd(16'hfe1e, d, r);
      chk("unmapped resp", {30'h0000_0000, r}, {30'h0000_0000, RESP_SLVERR});
      wr(IDX_ATR_HIGH, 8'ha5);
      wr(IDX_ATR_LOW, 8'h3c);
      rd(IDX_ATR_HIGH, d, r);
      chk("limit high", d, 32'h0000_00a5);
      rd(IDX_ATR_LOW, d, r);
      chk("limit low", d, 32'h0000_003c);
      wr(IDX_RELEASE_DELAY, 8'h00);
      card_supply_good <= 1'b1;
      wait_on(0, n);
      rng("zero delay release", n, 1, 3);
      // hold across power-up; 32 cycles per etu from here on
      wr(IDX_SIGNAL_CTL, 8'h80);
      card_supply_good <= 1'b0;
      wr(IDX_FD_CTL, 8'h96);
      wr(IDX_RELEASE_DELAY, 8'h03);
      card_supply_good <= 1'b1;
      repeat (40) @(posedge ref_clk);
      chk("held", {31'h0000_0000, card_rst_n[0]}, 32'h0000_0000);
      wr(IDX_SIGNAL_CTL, 8'h00);
      wait_on(0, n);
      rng("release delay", n, 60, 100);
      interface_select <= 1'b1;
      cycle_hold();
      rng("second interface", n, 60, 100);
      wr(IDX_SIGNAL_CTL, 8'h80);
      @(posedge ref_clk);
      chk("pins sel 1", {30'h0000_0000, card_rst_n}, 32'h0000_0001);
      interface_select <= 1'b0;
      repeat (3) @(posedge ref_clk);
      chk("pins sel 0", {30'h0000_0000, card_rst_n}, 32'h0000_0000);
      // silent card trips the initial char timer
      card_mute <= 1'b1;
      wr(IDX_INIT_CHAR, 8'h02);
      wr(IDX_BYTE_TIMING, 8'h40);
      wr(IDX_SIGNAL_CTL, 8'h00);
      wait_on(0, n);
      wait_on(1, n);
      rng("mute time", n, 60, 102);
      repeat (50) @(posedge ref_clk);
      rd(IDX_TIMER_STATUS, d, r);
      chk("status set", d, 32'h0000_0003);
      wr(IDX_TIMER_STATUS, 8'h03);
      rd(IDX_TIMER_STATUS, d, r);
      chk("status clear", d, 32'h0000_0000);
      // prompt card, answer timer not armed
      card_mute <= 1'b0;
      cycle_hold();
      repeat (300) @(posedge ref_clk);
      chk("flags quiet", {30'h0000_0000, mute_card, answer_timeout}, 32'h0000_0000);
      wr(IDX_ATR_LOW, 8'h03);
      wr(IDX_ATR_HIGH, 8'h00);
      wr(IDX_BYTE_TIMING, 8'h00);
      wr(IDX_PROTOCOL_CFG, 8'h01);
      cycle_hold();
      wait_on(2, n);
      rng("answer time", n, 130, 180);
      chk("no mute", {31'h0000_0000, mute_card}, 32'h0000_0000);
      test_done();
   end

endmodule
